// ### dv/divided_oscillator_output_enable_tb.sv
// Purpose: Self-checking bench for the divided oscillator output block
// Assumes: Two i_clock ticks per master period
// Notes: Pin counts are taken from values sampled at rising edges
`timescale 1ns/100ps
`default_nettype none
module divided_oscillator_output_enable_tb;
   import osc_div_pkg::*;
   logic i_clock, i_reset_n, i_read, i_write, set_enable, seen;
   logic o_pin_out, o_pin_oe, o_waitrequest, output_enable;
   logic [3:0] i_address, i_byteenable, set_code;
   logic [7:0] div_level;
   logic [31:0] i_writedata, o_readdata, rd, old;
   int n_mismatch = 0, n_tests = 0, cycles = 0, k, n, m;

   osc_enable_driver i_drv (.i_clock(i_clock), .i_set_enable(set_enable),
      .i_set_code(set_code), .o_output_enable(output_enable), .o_div_level(div_level));
   divided_oscillator_output_enable i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_div_level(div_level), .i_output_enable(output_enable), .o_pin_out(o_pin_out),
      .o_pin_oe(o_pin_oe), .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest));

   initial begin
      i_clock = 1'b0;
      forever #(CLOCK_PERIOD_NS / 2) i_clock = ~i_clock;
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic chk_le(input string nm, input int lim, input int got);
      n_tests++;
      if (got > lim) begin
         n_mismatch++;
         $display("MISMATCH %s exp <= %0d got %0d", nm, lim, got);
      end
   endtask

   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int t;
      repeat (2) @(posedge i_clock);
      i_address <= a;
      i_writedata <= d;
      i_byteenable <= be;
      i_read <= ~wr;
      i_write <= wr;
      t = 0;
      do begin
         @(posedge i_clock);
         t++;
      end while (o_waitrequest !== 1'b0 && t < 20);
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      chk("bus answer", 0, 32'(o_waitrequest));
   endtask

   function automatic logic [31:0] ratio_of(input logic [3:0] c);
      return 32'h1 << ((c > 4'h7) ? 4'hf - c : c);
   endfunction

   // Poll the ratio; only the old or the new value may ever show
   task automatic wait_ratio(input logic [31:0] o, input logic [31:0] nw);
      int t;
      for (t = 0; t < 300; t++) begin
         bus(1'b0, REG_RATIO, 0, 4'hf, rd);
         if (rd === nw)
            break;
         if (rd !== o)
            chk("ratio step", o, rd);
      end
      chk("ratio", nw, rd);
   endtask

   task automatic until_pin(input logic v, output int c);
      c = 0;
      do begin
         @(posedge i_clock);
         c++;
      end while (o_pin_out !== v && c < 600);
   endtask

   task automatic power_up();
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      chk("oe in reset", 0, 32'(o_pin_oe));
      chk("wait in reset", 1, 32'(o_waitrequest));
      i_reset_n <= 1'b1;
      seen = 1'b0;
      repeat (START_CLOCKS - 10) begin
         @(posedge i_clock);
         seen = seen | o_pin_oe;
      end
      chk("oe at start", 0, 32'(seen));
   endtask

   // Cut a high pulse by dropping enable, then check the pin at once
   task automatic cut_pulse(input logic exp_oe);
      until_pin(1'b1, n);
      set_enable <= 1'b0;
      @(posedge i_clock);
      #1;
      chk("out cut", 0, 32'(o_pin_out));
      chk("oe off", 32'(exp_oe), 32'(o_pin_oe));
      repeat (20) @(posedge i_clock);
      chk("out held", 0, 32'(o_pin_out));
      set_enable <= 1'b1;
   endtask

   initial begin
      i_reset_n = 1'b0;
      i_read = 1'b0;
      i_write = 1'b0;
      i_address = 4'h0;
      i_writedata = 32'h0;
      i_byteenable = 4'hf;
      set_enable = 1'b0;
      set_code = 4'h2;
      power_up();
      repeat (100) @(posedge i_clock);
      chk("oe late start", 1, 32'(o_pin_oe));
      chk("out late start", 0, 32'(o_pin_out));
      bus(1'b0, REG_CTRL, 0, 4'hf, rd);
      chk("ctrl reset", 0, rd);
      bus(1'b1, REG_CTRL, 32'hf1, 4'h0, rd);
      bus(1'b0, REG_CTRL, 0, 4'hf, rd);
      chk("ctrl lane off", 0, rd);
      bus(1'b0, 4'hc, 0, 4'hf, rd);
      chk("unmapped", 0, rd);
      bus(1'b1, REG_CTRL, 32'h51, 4'h1, rd);
      bus(1'b0, REG_CTRL, 0, 4'hf, rd);
      chk("ctrl", 32'h51, rd);
      wait_ratio(4, 32);
      bus(1'b1, REG_CTRL, 0, 4'h1, rd);
      wait_ratio(32, 4);
      set_enable <= 1'b1;
      until_pin(1'b1, n);
      chk_le("enable delay", 10, n);
      until_pin(1'b0, n);
      chk("first pulse", 4, 32'(n));
      for (k = 0; k < 16; k++) begin
         old = ratio_of(set_code);
         set_code <= 4'(k);
         wait_ratio(old, ratio_of(4'(k)));
         m = 0;
         do begin
            bus(1'b0, REG_STATUS, 0, 4'hf, rd);
            m++;
         end while (rd[3:0] !== 4'(k) && m < 100);
         chk("code", 32'({k[3], 4'(k)}), 32'(rd[4:0]));
         repeat (2) begin
            until_pin(1'b1, n);
            until_pin(1'b0, n);
         end
         chk("half period", ratio_of(4'(k)), 32'(n));
         if (k == 14) cut_pulse(1'b0);
      end
      cut_pulse(1'b0);
      set_code <= 4'h3;
      wait_ratio(1, 8);
      cut_pulse(1'b1);
      until_pin(1'b1, n);
      chk_le("enable delay", 10, n);
      until_pin(1'b0, n);
      chk("first pulse", 8, 32'(n));
      set_code <= 4'hb;
      wait_ratio(8, 16);
      cut_pulse(1'b0);
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_pin_oe !== 1'b1 && n < 20);
      chk("low before rise", 0, 32'(o_pin_out));
      until_pin(1'b1, m);
      chk_le("enable delay", 10, n + m);
      until_pin(1'b0, n);
      chk("first pulse", 16, 32'(n));
      set_code <= 4'hd;
      power_up();
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_pin_oe !== 1'b1 && n < 200);
      until_pin(1'b1, n);
      chk("start low", CLOCKS_PER_MASTER, 32'(n));
      until_pin(1'b0, n);
      chk("start pulse", 4, 32'(n));
      summarize();
   end
endmodule
`default_nettype wire

// ### dv/osc_enable_driver.sv
// Purpose: Far-side logic driving the output enable and divider pin level
// Assumes: The bench issues commands just after rising edges of i_clock
// Notes: Pin level sits in the middle of the commanded code band
`timescale 1ns/100ps
`default_nettype none
module osc_enable_driver (
   input wire logic i_clock,
   input wire logic i_set_enable,
   input wire logic [3:0] i_set_code,
   output logic o_output_enable,
   output logic [7:0] o_div_level
);
   initial begin
      o_output_enable = 1'b0;
      o_div_level = 8'h28;
   end
   // Level only moves when commanded, then holds
   always @(posedge i_clock) begin
      o_output_enable <= i_set_enable;
      o_div_level <= {i_set_code, 4'h8};
   end
endmodule
`default_nettype wire

// ### hw/divided_oscillator_output_enable.sv
// Purpose: Divider selection, power-of-two clock divider and output enable gating
// Assumes: i_clock is the master oscillator at two ticks per master period
// Notes: Registers on Avalon-MM; output disable acts without the clock
`timescale 1ns/100ps
`default_nettype none
module divided_oscillator_output_enable (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [osc_div_pkg::LEVEL_W-1:0] i_div_level,
   input wire logic i_output_enable,
   output logic o_pin_out,
   output logic o_pin_oe,
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest
);
   import osc_div_pkg::*;

   logic [LEVEL_W-1:0] level_sync;
   logic oe_sync;
   logic [CODE_W-1:0] pin_code;
   logic [CODE_W-1:0] sel_code;
   logic [CODE_W-1:0] cand_code;
   logic [CODE_W-1:0] divider_select_code;
   logic [STAB_W-1:0] stab_cnt;
   logic [STAB_W-1:0] stab_need;
   logic [START_W-1:0] start_cnt;
   logic start_done;
   phase_t phase;
   logic started;
   logic float_when_disabled_bit;
   logic run;
   logic [HALF_W-1:0] half;
   logic [HALF_W-1:0] next_half;
   logic [HALF_W-1:0] lead;
   logic [HALF_W-1:0] cnt;
   logic toggle;
   logic kill_n;
   logic drive_kill_n;
   logic ctrl_override;
   logic [CODE_W-1:0] ctrl_code;
   logic bus_req;
   logic bus_take;
   logic [31:0] next_readdata;

   pin_sync3 #(.WIDTH(LEVEL_W)) u_level_sync (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_async(i_div_level),
      .o_level(level_sync)
   );

   pin_sync3 #(.WIDTH(1)) u_oe_sync (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_async(i_output_enable),
      .o_level(oe_sync)
   );

   // Selection code from the pin, or from software when overridden
   assign pin_code = code_of(level_sync);
   assign sel_code = ctrl_override ? ctrl_code : pin_code;
   assign started = (phase == PH_RUNNING);
   assign float_when_disabled_bit = divider_select_code[CODE_W-1];
   assign next_half = half_of(divider_select_code);
   assign stab_need = started ? recog_of(cand_code, divider_select_code)
                              : STAB_W'(START_STABLE_CLOCKS);
   assign start_done = (start_cnt == START_W'(START_CLOCKS));
   assign toggle = (cnt == half - HALF_W'(1));
   assign lead = (next_half == HALF_W'(1)) ? HALF_W'(LEAD_SHORT_CLOCKS)
                                           : HALF_W'(LEAD_LONG_CLOCKS);

   // Disable paths act without the clock
   assign kill_n = i_reset_n & i_output_enable;
   assign drive_kill_n = i_reset_n & (i_output_enable | ~float_when_disabled_bit);

   // Candidate code must hold still before it is taken
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cand_code <= '0;
         stab_cnt <= '0;
      end else if (sel_code != cand_code) begin
         cand_code <= sel_code;
         stab_cnt <= '0;
      end else if (stab_cnt != '1) begin
         stab_cnt <= stab_cnt + STAB_W'(1);
      end
   end

   // Jump straight to the settled code; no intermediate values
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         divider_select_code <= '0;
      end else if (stab_cnt >= stab_need && cand_code == sel_code) begin
         divider_select_code <= cand_code;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         start_cnt <= '0;
      end else if (!start_done) begin
         start_cnt <= start_cnt + START_W'(1);
      end
   end

   // Start-up ends once the timer ran out and the code is stable
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase <= PH_POWER_UP;
      end else begin
         unique case (phase)
            PH_POWER_UP: begin
               if (start_done && stab_cnt >= STAB_W'(START_STABLE_CLOCKS)
                   && divider_select_code == cand_code
                   && cand_code == sel_code) begin
                  phase <= PH_RUNNING;
               end
            end
            PH_RUNNING: begin
               phase <= PH_RUNNING;
            end
         endcase
      end
   end

   // Run only after the synchronised enable; cleared at once by enable low
   always_ff @(posedge i_clock or negedge kill_n) begin
      if (!kill_n) begin
         run <= 1'b0;
      end else begin
         run <= started & oe_sync;
      end
   end

   // New ratio only at the end of a high half, or while stopped
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         half <= HALF_W'(1);
      end else if (!run || (toggle && o_pin_out)) begin
         half <= next_half;
      end
   end

   // Preload makes the first low phase last the lead time
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt <= '0;
      end else if (!run) begin
         cnt <= next_half - lead;
      end else if (toggle) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + HALF_W'(1);
      end
   end

   // Pin level: low while stopped, truncated at once by enable low
   always_ff @(posedge i_clock or negedge kill_n) begin
      if (!kill_n) begin
         o_pin_out <= 1'b0;
      end else if (!run) begin
         o_pin_out <= 1'b0;
      end else if (toggle) begin
         o_pin_out <= ~o_pin_out;
      end
   end

   // Pin drive: floats in start-up, float mode releases at once on disable
   always_ff @(posedge i_clock or negedge drive_kill_n) begin
      if (!drive_kill_n) begin
         o_pin_oe <= 1'b0;
      end else begin
         o_pin_oe <= started & (oe_sync | ~float_when_disabled_bit);
      end
   end

   // Avalon slave: one wait cycle, then answer
   assign bus_req = i_read | i_write;
   assign bus_take = bus_req & ~o_waitrequest;

   always_comb begin
      next_readdata = '0;
      unique case (i_address)
         REG_CTRL: begin
            next_readdata[CTRL_OVERRIDE_BIT] = ctrl_override;
            next_readdata[CTRL_CODE_LSB +: CODE_W] = ctrl_code;
         end
         REG_STATUS: begin
            next_readdata[STAT_CODE_LSB +: CODE_W] = divider_select_code;
            next_readdata[STAT_FLOAT_BIT] = float_when_disabled_bit;
            next_readdata[STAT_STARTED_BIT] = started;
            next_readdata[STAT_RUN_BIT] = run;
            next_readdata[STAT_PIN_CODE_LSB +: CODE_W] = pin_code;
         end
         REG_RATIO: begin
            next_readdata[HALF_W-1:0] = half;
         end
         default: begin
            next_readdata = '0;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_waitrequest <= 1'b1;
      end else begin
         o_waitrequest <= ~(bus_req & o_waitrequest);
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_readdata <= '0;
      end else if (i_read && o_waitrequest) begin
         o_readdata <= next_readdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_override <= CTRL_OVERRIDE_RESET;
         ctrl_code <= CTRL_CODE_RESET;
      end else if (bus_take && i_write && i_address == REG_CTRL && i_byteenable[0]) begin
         ctrl_override <= i_writedata[CTRL_OVERRIDE_BIT];
         ctrl_code <= i_writedata[CTRL_CODE_LSB +: CODE_W];
      end
   end

   // Checks
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_lead_low;
      !o_pin_out ##1 !o_pin_out;
   endsequence

   sequence s_first_rise;
      ($rose(run) && half == HALF_W'(2)) ##1 run [*2];
   endsequence

   property p_disabled_low;
      !i_output_enable |-> !o_pin_out;
   endproperty
   a_disabled_low: assert property (p_disabled_low)
      else $error("output high while enable low");

   property p_float_released;
      (!i_output_enable && float_when_disabled_bit) |-> !o_pin_oe;
   endproperty
   a_float_released: assert property (p_float_released)
      else $error("pin driven while disabled in float mode");

   property p_held_low;
      (started && $past(started) && !float_when_disabled_bit
       && $past(!float_when_disabled_bit)) |-> o_pin_oe;
   endproperty
   a_held_low: assert property (p_held_low)
      else $error("pin not driven after start-up in low mode");

   property p_startup_float;
      !started |-> (!o_pin_oe && !o_pin_out);
   endproperty
   a_startup_float: assert property (p_startup_float)
      else $error("pin active during start-up");

   property p_start_wait;
      $rose(started) |-> ($past(start_cnt) == START_W'(START_CLOCKS)
                          && $past(stab_cnt) >= STAB_W'(START_STABLE_CLOCKS));
   endproperty
   a_start_wait: assert property (p_start_wait)
      else $error("start-up ended before timer and stable code");

   property p_ratio_map;
      !run && !$past(run) && $stable(divider_select_code) |-> half == half_of(divider_select_code);
   endproperty
   a_ratio_map: assert property (p_ratio_map)
      else $error("stopped divider ratio differs from code");

   property p_no_intermediate;
      $changed(divider_select_code) |-> divider_select_code == $past(cand_code)
         && $past(stab_cnt) >= $past(stab_need);
   endproperty
   a_no_intermediate: assert property (p_no_intermediate)
      else $error("selection code taken before it settled");

   property p_square;
      (run && $past(run) && $changed(o_pin_out)) |->
         ($past(cnt) == $past(half) - HALF_W'(1));
   endproperty
   a_square: assert property (p_square)
      else $error("output toggled off the half-period count");

   property p_lead;
      ($rose(run) && half == HALF_W'(1)) ##1 run |-> o_pin_out && !$past(o_pin_out);
   endproperty
   a_lead: assert property (p_lead)
      else $error("ratio one first rise not after half an output period");

   property p_first_low;
      ($rose(run) && next_half > HALF_W'(1)) |-> s_lead_low;
   endproperty
   a_first_low: assert property (p_first_low)
      else $error("first output phase not held low");

   property p_first_rise;
      s_first_rise |-> o_pin_out && !$past(o_pin_out) && !$past(o_pin_out, 2);
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("ratio two first rise not after two low clocks");

   property p_toggles;
      run |-> ##[1:130] ($changed(o_pin_out) || !run);
   endproperty
   a_toggles: assert property (p_toggles)
      else $error("enabled output not toggling");
endmodule
`default_nettype wire

// ### hw/pin_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: i_async comes from outside the i_clock domain
// Notes: Output follows only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_level <= '0;
      end else if (stage2 == stage3) begin
         o_level <= stage3;
      end
   end
endmodule
`default_nettype wire

// ### shared/osc_div_pkg.sv
// Purpose: Constants, types and helpers shared by the divided oscillator output block
// Assumes: i_clock ticks twice per master oscillator period (one tick per half period)
// Notes: All counts are in i_clock cycles unless the name says otherwise
`default_nettype none
package osc_div_pkg;
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int CLOCKS_PER_MASTER = 2;
   localparam int START_MASTER_PERIODS = 500;
   localparam int START_CLOCKS = START_MASTER_PERIODS * CLOCKS_PER_MASTER;
   localparam int START_STABLE_MASTER = 16;
   localparam int START_STABLE_CLOCKS = START_STABLE_MASTER * CLOCKS_PER_MASTER;
   localparam int RECOG_MASTER_PER_STEP = 16;
   localparam int RECOG_OFFSET_STEPS = 6;
   localparam int CODE_W = 4;
   localparam int LEVEL_W = 8;
   localparam int HALF_W = 8;
   localparam int STAB_W = 11;
   localparam int START_W = 11;
   localparam int LEAD_SHORT_CLOCKS = 1;
   localparam int LEAD_LONG_CLOCKS = 2;
   localparam int CODE_MID = 7;
   localparam int CODE_TOP = 15;

   // Register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RATIO = 4'h8;
   // Control fields
   localparam int CTRL_OVERRIDE_BIT = 0;
   localparam int CTRL_CODE_LSB = 4;
   localparam logic CTRL_OVERRIDE_RESET = 1'b0;
   localparam logic [CODE_W-1:0] CTRL_CODE_RESET = 4'h0;
   // Status fields
   localparam int STAT_CODE_LSB = 0;
   localparam int STAT_FLOAT_BIT = 4;
   localparam int STAT_STARTED_BIT = 5;
   localparam int STAT_RUN_BIT = 6;
   localparam int STAT_PIN_CODE_LSB = 8;

   typedef enum logic {PH_POWER_UP, PH_RUNNING} phase_t;

   // Quantise the pin-to-supply ratio: code boundaries at multiples of 1/16
   function automatic logic [CODE_W-1:0] code_of(input logic [LEVEL_W-1:0] level);
      code_of = level[LEVEL_W-1 -: CODE_W];
   endfunction

   // Clocks per half output period, equal to the division ratio
   function automatic logic [HALF_W-1:0] half_of(input logic [CODE_W-1:0] code);
      logic [CODE_W-1:0] e;
      e = (code > 4'(CODE_MID)) ? 4'(CODE_TOP) - code : code;
      half_of = HALF_W'(1) << e;
   endfunction

   // Stable time before a changed code is taken, in clocks
   function automatic logic [STAB_W-1:0] recog_of(input logic [CODE_W-1:0] a,
                                                  input logic [CODE_W-1:0] b);
      logic [CODE_W-1:0] d;
      d = (a > b) ? a - b : b - a;
      recog_of = STAB_W'((32'(d) + RECOG_OFFSET_STEPS) * RECOG_MASTER_PER_STEP
                         * CLOCKS_PER_MASTER);
   endfunction
endpackage
`default_nettype wire
